/* File: include/itb_regs.vh */
`ifndef ITB_REGS_VH
`define ITB_REGS_VH

// Register byte offsets
`define ITB_OFS_PSC_CTRL 8'h00
`define ITB_OFS_TB0_CTRL 8'h04
`define ITB_OFS_TB1_CTRL 8'h08
`define ITB_OFS_IRQ_EN 8'h0C
`define ITB_OFS_IRQ_FLAG 8'h10
`define ITB_OFS_IRQ_STAT 8'h14

// Prescaler control fields
`define ITB_PSC_ON_BIT 2
`define ITB_PSC_SRC_LSB 0
`define ITB_PSC_SRC_W 2
`define ITB_PSC_CTRL_RST 3'h0

// Prescaler source codes
`define ITB_SRC_SYS 2'h0
`define ITB_SRC_DIV4 2'h1
`define ITB_SRC_DIV2 2'h2
`define ITB_SRC_SUB 2'h3

// Time base control fields
`define ITB_TB_ON_BIT 7
`define ITB_TB_SEL_LSB 0
`define ITB_TB_SEL_W 3
`define ITB_TB_CTRL_RST 4'h0

// Shortest period exponent per time base
`define ITB_TB0_EXP_BASE 5'h04
`define ITB_TB1_EXP_BASE 5'h08

// Interrupt enable register: bit 31 global, low bits per source
`define ITB_GIE_BIT 31
`define ITB_NSRC 11
`define ITB_SRC_EN_RST 11'h000
`define ITB_FLAG_RST 11'h000

// Source indices, lowest index has the highest priority
`define ITB_IX_CMP0 0
`define ITB_IX_CMP1 1
`define ITB_IX_GRP0 2
`define ITB_IX_GRP1 3
`define ITB_IX_CONV 4
`define ITB_IX_TICK0 5
`define ITB_IX_TICK1 6
`define ITB_IX_SERIAL 7
`define ITB_IX_LOWVOLT 8
`define ITB_IX_EEPROM 9
`define ITB_IX_UART 10

// AXI responses
`define ITB_RESP_OKAY 2'h0
`define ITB_RESP_SLVERR 2'h2

`endif

/* File: rtl/itb_irq_timebase.v */
// What this block does
// - Comparator output change sets its request flag
// - Vector only with global and source enable
// - No vector while the return stack full
// - Comparator service clears flag and global enable
// - Group flag set when any member sets
// - Group service clears group flag and global enable, not member flags
// - Conversion done sets flag, service clears it
// - Time base overflow sets flag, service clears
// - Source field picks sys, /4, /2, sub
// - Prescaler enable gates clock, resets off
// - Time base 0 period two^4..two^11
// - Time base 1 period two^8..two^15
// - Unimplemented control bits read zero
// - Serial byte, match, timeout set flag
// - Low supply sets flag, service clears
// - EEPROM erase or write end sets flag
// - Six UART events raise the request
// - UART service leaves UART status alone
// - Any flag rising wakes the device
// - Return from interrupt sets global enable
`timescale 1ns/1ps
`include "itb_regs.vh"

module itb_irq_timebase #(
  parameter AW = 8,
  parameter TB_CNT_W = 16,
  parameter GRP_W = 4
) (
  input wire mclk,
  input wire resetn,
  // AXI4-Lite slave
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Event sources
  input wire [1:0] cmp_out,
  input wire [GRP_W-1:0] grp0_member_flags,
  input wire [GRP_W-1:0] grp1_member_flags,
  input wire conv_done,
  input wire [2:0] serial_evt,
  input wire lowvolt_det,
  input wire [1:0] eeprom_done,
  input wire [5:0] uart_evt,
  input wire sub_clk,
  // CPU core side
  input wire cpu_stack_full,
  input wire cpu_irq_ack,
  input wire cpu_return_from_irq,
  output reg irq_req_q,
  output reg [3:0] irq_vec_q,
  output reg wake_q,
  output reg prescaler_clk_q
);

  localparam NS = `ITB_NSRC;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for inputs from other domains
  reg [1:0] cmp_s1_q;
  reg [1:0] cmp_s2_q;
  reg [1:0] cmp_s3_q;
  reg lv_s1_q;
  reg lv_s2_q;
  reg lv_s3_q;
  reg sub_s1_q;
  reg sub_s2_q;
  reg sub_s3_q;
  reg [GRP_W-1:0] grp0_prev_q;
  reg [GRP_W-1:0] grp1_prev_q;

  // Comparators, detector and sub clock are asynchronous to mclk
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmp_s1_q <= 2'h0;
      cmp_s2_q <= 2'h0;
      cmp_s3_q <= 2'h0;
      lv_s1_q <= 1'b0;
      lv_s2_q <= 1'b0;
      lv_s3_q <= 1'b0;
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
      grp0_prev_q <= {GRP_W{1'b0}};
      grp1_prev_q <= {GRP_W{1'b0}};
    end else begin
      cmp_s1_q <= cmp_out;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      lv_s1_q <= lowvolt_det;
      lv_s2_q <= lv_s1_q;
      lv_s3_q <= lv_s2_q;
      sub_s1_q <= sub_clk;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
      grp0_prev_q <= grp0_member_flags;
      grp1_prev_q <= grp1_member_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  reg [2:0] psc_ctrl_q;
  reg [3:0] tb0_ctrl_q;
  reg [3:0] tb1_ctrl_q;
  reg [NS-1:0] src_en_q;
  reg gie_q;
  reg [NS-1:0] flag_q;

  wire psc_on = psc_ctrl_q[`ITB_PSC_ON_BIT];
  wire [1:0] psc_src = psc_ctrl_q[1:0];
  wire tick0_on = tb0_ctrl_q[3];
  wire tick1_on = tb1_ctrl_q[3];
  wire [2:0] tick0_period_sel = tb0_ctrl_q[2:0];
  wire [2:0] tick1_period_sel = tb1_ctrl_q[2:0];

  ////////////////////////////////////////////////////////////////////////
  // Prescaler clock: one-cycle tick per prescaler period
  reg [1:0] div_q;
  reg psc_tick;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 2'h0;
    end else if (psc_on) begin
      div_q <= div_q + 2'h1;
    end else begin
      div_q <= 2'h0;
    end
  end

  // Sub clock rising edge gives one tick per sub period
  always @* begin
    psc_tick = 1'b0;
    case (psc_src)
      `ITB_SRC_SYS: psc_tick = 1'b1;
      `ITB_SRC_DIV4: psc_tick = (div_q == 2'h3);
      `ITB_SRC_DIV2: psc_tick = div_q[0];
      `ITB_SRC_SUB: psc_tick = sub_s2_q & ~sub_s3_q;
      default: psc_tick = 1'b0;
    endcase
    psc_tick = psc_tick & psc_on;
  end

  // Visible prescaler clock, toggles per tick and stops when off
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prescaler_clk_q <= 1'b0;
    end else if (!psc_on) begin
      prescaler_clk_q <= 1'b0;
    end else if (psc_tick) begin
      prescaler_clk_q <= ~prescaler_clk_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time base counters
  reg [TB_CNT_W-1:0] tb0_cnt_q;
  reg [TB_CNT_W-1:0] tb1_cnt_q;
  wire [4:0] tb0_exp = `ITB_TB0_EXP_BASE + {2'h0, tick0_period_sel};
  wire [4:0] tb1_exp = `ITB_TB1_EXP_BASE + {2'h0, tick1_period_sel};
  wire [TB_CNT_W-1:0] tb0_mask = ({{(TB_CNT_W-1){1'b0}}, 1'b1} << tb0_exp) - 1'b1;
  wire [TB_CNT_W-1:0] tb1_mask = ({{(TB_CNT_W-1){1'b0}}, 1'b1} << tb1_exp) - 1'b1;
  // Wrap of the selected low bits is the overflow
  wire tb0_ovf = tick0_on & psc_tick & ((tb0_cnt_q & tb0_mask) == tb0_mask);
  wire tb1_ovf = tick1_on & psc_tick & ((tb1_cnt_q & tb1_mask) == tb1_mask);

  // Counters clear while off so the first period after on is whole
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tb0_cnt_q <= {TB_CNT_W{1'b0}};
      tb1_cnt_q <= {TB_CNT_W{1'b0}};
    end else begin
      if (!tick0_on) begin
        tb0_cnt_q <= {TB_CNT_W{1'b0}};
      end else if (psc_tick) begin
        tb0_cnt_q <= tb0_cnt_q + 1'b1;
      end
      if (!tick1_on) begin
        tb1_cnt_q <= {TB_CNT_W{1'b0}};
      end else if (psc_tick) begin
        tb1_cnt_q <= tb1_cnt_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source events
  reg [NS-1:0] evt;

  always @* begin
    evt = {NS{1'b0}};
    evt[`ITB_IX_CMP0] = cmp_s2_q[0] ^ cmp_s3_q[0];
    evt[`ITB_IX_CMP1] = cmp_s2_q[1] ^ cmp_s3_q[1];
    evt[`ITB_IX_GRP0] = |(grp0_member_flags & ~grp0_prev_q);
    evt[`ITB_IX_GRP1] = |(grp1_member_flags & ~grp1_prev_q);
    evt[`ITB_IX_CONV] = conv_done;
    evt[`ITB_IX_TICK0] = tb0_ovf;
    evt[`ITB_IX_TICK1] = tb1_ovf;
    evt[`ITB_IX_SERIAL] = |serial_evt;
    evt[`ITB_IX_LOWVOLT] = lv_s2_q & ~lv_s3_q;
    evt[`ITB_IX_EEPROM] = |eeprom_done;
    evt[`ITB_IX_UART] = |uart_evt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Fixed priority pick among enabled pending requests
  wire [NS-1:0] pending = flag_q & src_en_q;
  reg [3:0] pick;
  integer k;

  // Lowest index wins, the others stay pending
  always @* begin
    pick = 4'h0;
    for (k = NS - 1; k >= 0; k = k - 1) begin
      if (pending[k]) begin
        pick = k[3:0];
      end
    end
  end

  // Request drops the cycle after the ack cycle so one ack takes one vector
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_req_q <= 1'b0;
      irq_vec_q <= 4'h0;
    end else begin
      irq_req_q <= gie_q & (|pending) & ~cpu_stack_full & ~cpu_irq_ack;
      irq_vec_q <= pick;
    end
  end

  wire svc = cpu_irq_ack & irq_req_q;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  reg aw_held_q;
  reg [AW-1:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_q | aw_take;
  wire w_have = w_held_q | w_take;
  wire [AW-1:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  wire wr_go = aw_have & w_have & ~s_axi_bvalid;
  wire wr_hit = (wr_addr == `ITB_OFS_PSC_CTRL) | (wr_addr == `ITB_OFS_TB0_CTRL) |
                (wr_addr == `ITB_OFS_TB1_CTRL) | (wr_addr == `ITB_OFS_IRQ_EN) |
                (wr_addr == `ITB_OFS_IRQ_FLAG) | (wr_addr == `ITB_OFS_IRQ_STAT);
  wire wr_en = wr_go & wr_hit & (wr_addr != `ITB_OFS_IRQ_STAT);

  // Address and data are accepted in either order, then answered
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ITB_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= {AW{1'b0}};
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_have & ~s_axi_bvalid;
      s_axi_wready <= ~w_have & ~s_axi_bvalid;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `ITB_RESP_OKAY : `ITB_RESP_SLVERR;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end else begin
        aw_held_q <= aw_have;
        w_held_q <= w_have;
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register writes use byte lane 0, source enables 8 up also lane 1, global enable lane 3
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      psc_ctrl_q <= `ITB_PSC_CTRL_RST;
      tb0_ctrl_q <= `ITB_TB_CTRL_RST;
      tb1_ctrl_q <= `ITB_TB_CTRL_RST;
      src_en_q <= `ITB_SRC_EN_RST;
    end else if (wr_en) begin
      if (wr_addr == `ITB_OFS_PSC_CTRL && wr_strb[0]) begin
        psc_ctrl_q <= wr_data[2:0];
      end
      if (wr_addr == `ITB_OFS_TB0_CTRL && wr_strb[0]) begin
        tb0_ctrl_q <= {wr_data[`ITB_TB_ON_BIT], wr_data[2:0]};
      end
      if (wr_addr == `ITB_OFS_TB1_CTRL && wr_strb[0]) begin
        tb1_ctrl_q <= {wr_data[`ITB_TB_ON_BIT], wr_data[2:0]};
      end
      if (wr_addr == `ITB_OFS_IRQ_EN) begin
        if (wr_strb[0]) begin
          src_en_q[7:0] <= wr_data[7:0];
        end
        if (wr_strb[1]) begin
          src_en_q[NS-1:8] <= wr_data[NS-1:8];
        end
      end
    end
  end

  // Global enable: service clears, return sets, software writes
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gie_q <= 1'b0;
    end else if (cpu_return_from_irq) begin
      gie_q <= 1'b1;
    end else if (svc) begin
      gie_q <= 1'b0;
    end else if (wr_en && wr_addr == `ITB_OFS_IRQ_EN && wr_strb[3]) begin
      gie_q <= wr_data[`ITB_GIE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request flags; a new event wins over any clear in the same cycle
  wire flag_wr = wr_en & (wr_addr == `ITB_OFS_IRQ_FLAG);
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_flag
      wire lane_ok = (gi < 8) ? wr_strb[0] : wr_strb[1];
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          flag_q[gi] <= 1'b0;
        end else if (evt[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (svc && irq_vec_q == gi) begin
          flag_q[gi] <= 1'b0;
        end else if (flag_wr && lane_ok) begin
          flag_q[gi] <= wr_data[gi];
        end
      end
    end
  endgenerate

  // Wake pulse on any flag rising, enables not consulted
  reg [NS-1:0] flag_prev_q;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flag_prev_q <= `ITB_FLAG_RST;
      wake_q <= 1'b0;
    end else begin
      flag_prev_q <= flag_q;
      wake_q <= |(flag_q & ~flag_prev_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path, one cycle from address to data
  reg [31:0] rd_mux;
  reg rd_hit;

  // Unused and reserved bits read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `ITB_OFS_PSC_CTRL: rd_mux[2:0] = psc_ctrl_q;
      `ITB_OFS_TB0_CTRL: rd_mux[7:0] = {tb0_ctrl_q[3], 4'h0, tb0_ctrl_q[2:0]};
      `ITB_OFS_TB1_CTRL: rd_mux[7:0] = {tb1_ctrl_q[3], 4'h0, tb1_ctrl_q[2:0]};
      `ITB_OFS_IRQ_EN: begin
        rd_mux[NS-1:0] = src_en_q;
        rd_mux[`ITB_GIE_BIT] = gie_q;
      end
      `ITB_OFS_IRQ_FLAG: rd_mux[NS-1:0] = flag_q;
      `ITB_OFS_IRQ_STAT: rd_mux[NS-1:0] = pending;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ITB_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `ITB_RESP_OKAY : `ITB_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: sim/itb_irq_timebase_checker.sv */
`timescale 1ns/1ps
`include "itb_regs.vh"
module itb_checker #(
  parameter AW = 8
) (
  input wire mclk,
  input wire resetn,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire cpu_stack_full,
  input wire cpu_irq_ack,
  input wire cpu_return_from_irq,
  input wire irq_req_q,
  input wire [3:0] irq_vec_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Read channel: answer one cycle after take, held until taken
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_unmap;
    s_axi_arvalid && s_axi_arready &&
      !(s_axi_araddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14})
      |=> s_axi_rresp == `ITB_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  ////////////////////////////////////////////////////////////
  // Unused control bits must read zero
  property p_psc_zero;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `ITB_OFS_PSC_CTRL
      |=> s_axi_rdata[31:3] == 29'h0;
  endproperty
  a_psc_zero: assert property (p_psc_zero) else $error("prescaler spare bits set");
  property p_tb_zero;
    s_axi_arvalid && s_axi_arready &&
      s_axi_araddr inside {`ITB_OFS_TB0_CTRL, `ITB_OFS_TB1_CTRL}
      |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:3] == 4'h0;
  endproperty
  a_tb_zero: assert property (p_tb_zero) else $error("time base spare bits set");
  ////////////////////////////////////////////////////////////
  // Vectoring: full stack blocks, service drops the request
  property p_stack;
    cpu_stack_full |=> !irq_req_q;
  endproperty
  a_stack: assert property (p_stack) else $error("vector with full stack");
  property p_ack;
    irq_req_q && cpu_irq_ack && !cpu_return_from_irq |=> !irq_req_q;
  endproperty
  a_ack: assert property (p_ack) else $error("request kept after service");
  property p_vec;
    irq_req_q |-> irq_vec_q <= 4'hA;
  endproperty
  a_vec: assert property (p_vec) else $error("vector out of range");
  c_ack: cover property (irq_req_q && cpu_irq_ack);
  c_full: cover property (cpu_stack_full && !irq_req_q);
  c_unmap: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14);
endmodule

/* File: sim/itb_cpu_model.sv */
`timescale 1ns/1ps
module itb_cpu_model (
  input wire mclk,
  input wire resetn,
  input wire irq_req_q,
  input wire ack_en,
  input wire auto_return_from_irq,
  output logic cpu_irq_ack,
  output logic cpu_return_from_irq
);
  logic [1:0] dly_q;
  logic busy_q;
  ////////////////////////////////////////////////////////////
  // Take a live vector, serve briefly; return held off while auto_return_from_irq is low
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpu_irq_ack <= 1'b0;
      cpu_return_from_irq <= 1'b0;
      dly_q <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      cpu_irq_ack <= ack_en && irq_req_q && !cpu_irq_ack && !busy_q;
      cpu_return_from_irq <= 1'b0;
      if (cpu_irq_ack && irq_req_q) begin
        busy_q <= 1'b1;
        dly_q <= 2'h2;
      end else if (busy_q && dly_q != 2'h0) begin
        dly_q <= dly_q - 2'h1;
      end else if (busy_q && auto_return_from_irq) begin
        cpu_return_from_irq <= 1'b1;
        busy_q <= 1'b0;
      end
    end
  end
endmodule

/* File: sim/itb_irq_timebase_tb.sv */
`timescale 1ns/1ps
`include "itb_regs.vh"
module itb_irq_timebase_tb;
  logic mclk, resetn, awv, wv, brdy, arv, rrdy, conv, lv, sub, full, ack_en, auto_return_from_irq;
  logic [7:0] awa, ara;
  logic [31:0] wd;
  logic [1:0] cmp, ee;
  logic [3:0] g0, g1;
  logic [2:0] ser;
  logic [5:0] ua;
  wire awr, wrdy, bv, arr, rv, irq, ack, return_from_irq, wake, pclk;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [3:0] vec;
  int error_cnt, comparisons, cyc;
  logic [3:0] vq[$];
  int tq[$];

  itb_irq_timebase dut (
    .mclk(mclk), .resetn(resetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .cmp_out(cmp),
    .grp0_member_flags(g0), .grp1_member_flags(g1), .conv_done(conv), .serial_evt(ser),
    .lowvolt_det(lv), .eeprom_done(ee), .uart_evt(ua), .sub_clk(sub),
    .cpu_stack_full(full), .cpu_irq_ack(ack), .cpu_return_from_irq(return_from_irq), .irq_req_q(irq),
    .irq_vec_q(vec), .wake_q(wake), .prescaler_clk_q(pclk));
  itb_cpu_model cpu (.mclk(mclk), .resetn(resetn), .irq_req_q(irq), .ack_en(ack_en),
    .auto_return_from_irq(auto_return_from_irq), .cpu_irq_ack(ack), .cpu_return_from_irq(return_from_irq));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  // Vector log with cycle stamps; sub clock is mclk over eight
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    sub <= cyc[2]; // Sole driver of the sub clock, period of eight mclk
    if (ack === 1'b1 && irq === 1'b1) begin
      vq.push_back(vec);
      tq.push_back(cyc);
    end
  end
  ////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task hang(input string n);
    error_cnt++;
    $display("ERROR %s expected answer seen none", n);
    conclude;
  endtask
  // Bus master: hold each channel until its ready, ready held for the answer
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    brdy <= 1'b0;
    if (k == 50) hang("write");
    chk("bresp", {30'h0, e}, {30'h0, br});
  endtask
  task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rrdy <= 1'b0;
    if (k == 50) hang(n);
    chk(n, e, rd);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask
  task wt(input int k, input int lim);
    int n;
    for (n = 0; n < lim && vq.size() < k; n++) @(posedge mclk);
    if (vq.size() < k) hang("vector");
  endtask
  // One event of source i; pulses last one cycle, comparators toggle
  task fire(input int i);
    @(posedge mclk);
    case (i)
      0: cmp[0] <= ~cmp[0];
      1: cmp[1] <= ~cmp[1];
      2: g0 <= 4'h1 << $urandom_range(3);
      3: g1 <= 4'h1 << $urandom_range(3);
      4: conv <= 1'b1;
      7: ser <= 3'h1 << $urandom_range(2);
      8: lv <= 1'b1;
      9: ee <= 2'h1 << $urandom_range(1);
      default: ua <= 6'h1 << $urandom_range(5);
    endcase
    @(posedge mclk);
    {conv, lv, ser, ee, ua, g0, g1} <= 21'h0;
  endtask
  function automatic int exp_period(int t, int s, int l);
    int dv[4] = '{1, 4, 2, 8};
    return (1 << (l + (t ? `ITB_TB1_EXP_BASE : `ITB_TB0_EXP_BASE))) * dv[s];
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    int i, k, n, src, sel;
    logic w;
    logic [31:0] r;
    {resetn, awv, wv, brdy, arv, rrdy, conv, lv, full, ack_en} = 10'h0;
    {awa, ara, wd, cmp, ee, g0, g1, ser, ua} = 69'h0;
    auto_return_from_irq = 1'b1;
    void'($urandom(68987));
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) rd_chk("reset value", 8'(4 * i), 32'h0, 2'h0);
    wr(8'h18, 32'hFFFF_FFFF, `ITB_RESP_SLVERR);
    rd_chk("unmapped", 8'h1C, 32'h0, `ITB_RESP_SLVERR);
    for (i = 0; i < 3; i++) begin
      r = $urandom;
      wr(8'(4 * i), r, 2'h0);
      rd_chk("control", 8'(4 * i), r & (i == 0 ? 32'h7 : 32'h87), 2'h0);
      wr(8'(4 * i), 32'h0, 2'h0);
    end
    wr(`ITB_OFS_IRQ_FLAG, 32'h0, 2'h0);
    $display("test registers done");
    ack_en <= 1'b1;
    for (i = 0; i < 12; i++) if (i % 11 != 5 && i % 11 != 6) begin
      fire(i % 11);
      w = 1'b0;
      for (n = 0; n < 8 && w !== 1'b1; n++) begin
        @(posedge mclk);
        w = wake;
      end
      chk("wake", 32'h1, {31'h0, w});
      rd_chk("event flag", `ITB_OFS_IRQ_FLAG, 32'h1 << (i % 11), 2'h0);
      wr(`ITB_OFS_IRQ_FLAG, 32'h0, 2'h0);
    end
    chk("vectors while disabled", 32'h0, vq.size());
    $display("test events done");
    full <= 1'b1;
    wr(`ITB_OFS_IRQ_EN, 32'h8000_0090, 2'h0);
    fire(7);
    fire(4);
    repeat (10) @(posedge mclk);
    chk("vectors with full stack", 32'h0, vq.size());
    full <= 1'b0;
    wt(2, 100);
    chk("first vector", 32'h4, {28'h0, vq[0]});
    chk("second vector", 32'h7, {28'h0, vq[1]});
    rd_chk("flags after service", `ITB_OFS_IRQ_FLAG, 32'h0, 2'h0);
    auto_return_from_irq <= 1'b0;
    fire(4);
    wt(3, 100);
    rd_chk("enable after service", `ITB_OFS_IRQ_EN, 32'h90, 2'h0);
    auto_return_from_irq <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk("enable after return", `ITB_OFS_IRQ_EN, 32'h8000_0090, 2'h0);
    $display("test vectoring done");
    wr(`ITB_OFS_IRQ_EN, 32'h8000_0020, 2'h0);
    wr(`ITB_OFS_TB0_CTRL, 32'h80, 2'h0);
    k = vq.size();
    n = 0;
    for (i = 0; i < 100; i++) begin
      @(posedge mclk);
      if (pclk !== 1'b0) n++;
    end
    chk("ticks with prescaler off", k, vq.size());
    chk("prescaler clock off", 32'h0, n);
    for (i = 0; i < 5; i++) begin
      src = i % 4;
      sel = i < 4 ? $urandom_range(2) : 0;
      k = i / 4;
      wr(`ITB_OFS_IRQ_EN, 32'h8000_0000 | (32'h20 << k), 2'h0);
      wr(`ITB_OFS_TB0_CTRL, 32'h0, 2'h0);
      wr(8'(4 + 4 * k), 32'h80 | sel, 2'h0);
      vq.delete();
      tq.delete();
      wr(`ITB_OFS_PSC_CTRL, 32'h4 | src, 2'h0);
      wt(3, 2000);
      chk("period", exp_period(k, src, sel), tq[2] - tq[1]);
      chk("tick vector", 32'h5 + k, {28'h0, vq[2]});
      // A 64-cycle window holds a whole number of prescaler ticks
      n = 0;
      w = pclk;
      repeat (64) begin
        @(posedge mclk);
        if (pclk !== w) n++;
        w = pclk;
      end
      chk("prescaler clock toggles", 1024 / exp_period(0, src, 0), n);
      wr(8'(4 + 4 * k), 32'h0, 2'h0);
      wr(`ITB_OFS_PSC_CTRL, 32'h0, 2'h0);
    end
    $display("test time base done");
    conclude;
  end
endmodule

bind itb_irq_timebase itb_checker #(.AW(AW)) u_chk (.mclk(mclk), .resetn(resetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cpu_stack_full(cpu_stack_full), .cpu_irq_ack(cpu_irq_ack),
  .cpu_return_from_irq(cpu_return_from_irq), .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q));
